/* File: verilog/tbi_io.sv */
`timescale 1ns/1ps
// Operation
// - every transmit code group passes one output flop right before the pad
// - forwarded transmit clock comes from a double-rate output register like the data
// - forwarded transmit clock is the inverse of the core clock
// - receive bus is captured on rising edges of two clocks half a cycle apart
// - capture splits the receive bus into two ten-bit buses, one per clock
// - each captured bus is registered again at once in its own domain
// - single-clock mode samples both edges of even clock, presents both on rising edge
// - single-clock mode feeds the even clock to both receive clock inputs
// - dual-clock mode uses both clocks, each bit arriving on two separate pads
// - one transmit reference clock may be shared by several instances
module tbi_io #(
	parameter int WIDTH = tbi_io_pkg::SYMBOL_WIDTH,
	parameter bit SINGLE_CLOCK_CAPTURE = 1'b1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] tx_symbols,
	output logic [WIDTH-1:0] tx_symbols_pad,
	output logic tx_clock_pad,
	input wire logic receive_clock_even,
	input wire logic receive_clock_odd,
	input wire logic [WIDTH-1:0] rx_symbols_even_pad,
	input wire logic [WIDTH-1:0] rx_symbols_odd_pad,
	output logic [WIDTH-1:0] captured_symbols_even,
	output logic [WIDTH-1:0] captured_symbols_odd,
	output logic [WIDTH-1:0] rx_symbols_even,
	output logic [WIDTH-1:0] rx_symbols_odd,
	output logic rx_symbols_valid
);

	logic [WIDTH-1:0] tx_symbols_q;
	logic tx_clock_rise_q;
	logic tx_clock_fall_q;
	logic tx_run_q;
	logic [7:0] stretch_q;
	logic link_rst_req;
	wire buffered_receive_clock_even;
	wire buffered_receive_clock_odd;
	logic even_rst1_q;
	logic even_rst_q;
	logic odd_rst1_q;
	logic odd_rst_q;
	logic [WIDTH-1:0] captured_even_q;
	logic [WIDTH-1:0] captured_odd_q;
	logic [WIDTH-1:0] core_even_q;
	logic [WIDTH-1:0] core_odd_q;
	logic even_valid;
	logic odd_valid;

	// the core clock domain is the only transmit domain; sharing it across instances is safe
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			tx_symbols_q <= tbi_io_pkg::SYMBOLS_RESET;
			tx_clock_rise_q <= tbi_io_pkg::TX_CLOCK_IDLE;
			tx_run_q <= 1'b0;
		end
		else
		begin
			tx_run_q <= 1'b1;
			tx_symbols_q <= tx_symbols;
			tx_clock_rise_q <= tbi_io_pkg::TX_CLOCK_FIRST_HALF;
		end
	end

	// second half of the double-rate clock register; reads a rising-edge flag, since
	// rst itself may move at the falling edge
	always_ff @(negedge clock)
	begin
		if (!tx_run_q)
			tx_clock_fall_q <= tbi_io_pkg::TX_CLOCK_IDLE;
		else
			tx_clock_fall_q <= tbi_io_pkg::TX_CLOCK_SECOND_HALF;
	end

	// ddr output mux: same register path as the data, so same pad delay
	assign tx_clock_pad = clock ? tx_clock_rise_q : tx_clock_fall_q;
	assign tx_symbols_pad = tx_symbols_q;

	// each instance has its own receive clocks; nothing here joins two instances
	assign buffered_receive_clock_even = receive_clock_even;
	assign buffered_receive_clock_odd = SINGLE_CLOCK_CAPTURE ? receive_clock_even
		: receive_clock_odd;

	// stretch reset so the slow link clocks are sure to see it
	always_ff @(posedge clock)
	begin
		if (rst)
			stretch_q <= 8'(tbi_io_pkg::RESET_STRETCH_CYCLES);
		else if (stretch_q != 8'h00)
			stretch_q <= stretch_q - 8'h01;
	end

	assign link_rst_req = rst || (stretch_q != 8'h00);

	// reset brought into each link domain through two flops
	always_ff @(posedge buffered_receive_clock_even)
	begin
		even_rst1_q <= link_rst_req;
		even_rst_q <= even_rst1_q;
	end

	always_ff @(posedge buffered_receive_clock_odd)
	begin
		odd_rst1_q <= link_rst_req;
		odd_rst_q <= odd_rst1_q;
	end

	// even bus: rising edge of the even clock, then the second register
	always_ff @(posedge buffered_receive_clock_even)
	begin
		if (even_rst_q)
		begin
			captured_even_q <= tbi_io_pkg::SYMBOLS_RESET;
			core_even_q <= tbi_io_pkg::SYMBOLS_RESET;
		end
		else
		begin
			captured_even_q <= rx_symbols_even_pad;
			core_even_q <= captured_even_q;
		end
	end

	generate
		if (SINGLE_CLOCK_CAPTURE)
		begin : g_single
			logic [WIDTH-1:0] fall_sample_q;
			// falling edge stands in for the odd clock; needs exact half-cycle phase
			always_ff @(negedge buffered_receive_clock_even)
			begin
				fall_sample_q <= rx_symbols_even_pad;
			end
			// same-edge: both samples appear together on the rising edge
			always_ff @(posedge buffered_receive_clock_even)
			begin
				if (even_rst_q)
				begin
					captured_odd_q <= tbi_io_pkg::SYMBOLS_RESET;
					core_odd_q <= tbi_io_pkg::SYMBOLS_RESET;
				end
				else
				begin
					captured_odd_q <= fall_sample_q;
					core_odd_q <= captured_odd_q;
				end
			end
		end
		else
		begin : g_dual
			// odd bits arrive on their own pads and their own clock
			always_ff @(posedge buffered_receive_clock_odd)
			begin
				if (odd_rst_q)
				begin
					captured_odd_q <= tbi_io_pkg::SYMBOLS_RESET;
					core_odd_q <= tbi_io_pkg::SYMBOLS_RESET;
				end
				else
				begin
					captured_odd_q <= rx_symbols_odd_pad;
					core_odd_q <= captured_odd_q;
				end
			end

			property p_dual_capture;
				@(posedge buffered_receive_clock_odd) disable iff (odd_rst_q)
				!$past(odd_rst_q) |-> captured_odd_q == $past(rx_symbols_odd_pad);
			endproperty
			a_dual_capture: assert property (p_dual_capture) else $error("odd pad not captured");
		end
	endgenerate

	assign captured_symbols_even = captured_even_q;
	assign captured_symbols_odd = captured_odd_q;

	// words cross into the core clock; the pair is marked valid once the even word has crossed
	symbol_crossing #(.WIDTH(WIDTH)) u_even_crossing (
		.link_clock(buffered_receive_clock_even),
		.link_rst(even_rst_q),
		.link_symbols(core_even_q),
		.clock(clock),
		.rst(link_rst_req),
		.symbols(rx_symbols_even),
		.symbols_valid(even_valid)
	);

	symbol_crossing #(.WIDTH(WIDTH)) u_odd_crossing (
		.link_clock(buffered_receive_clock_odd),
		.link_rst(odd_rst_q),
		.link_symbols(core_odd_q),
		.clock(clock),
		.rst(link_rst_req),
		.symbols(rx_symbols_odd),
		.symbols_valid(odd_valid)
	);

	// even word marks the pair; the odd one lands within a few cycles
	assign rx_symbols_valid = even_valid;

	property p_tx_registered;
		@(posedge clock) disable iff (rst)
		!$past(rst) |-> tx_symbols_pad == $past(tx_symbols);
	endproperty
	a_tx_registered: assert property (p_tx_registered) else $error("tx pad not one flop late");

	property p_tx_clock_inverted;
		@(posedge clock) disable iff (rst)
		!$past(rst) |-> tx_clock_fall_q == tbi_io_pkg::TX_CLOCK_SECOND_HALF
			&& tx_clock_rise_q == tbi_io_pkg::TX_CLOCK_FIRST_HALF;
	endproperty
	a_tx_clock_inverted: assert property (p_tx_clock_inverted) else $error("tx clock not inverted");

	property p_tx_clock_quiet;
		@(posedge clock)
		rst ##1 rst |-> tx_clock_rise_q == tbi_io_pkg::TX_CLOCK_IDLE
			&& tx_clock_fall_q == tbi_io_pkg::TX_CLOCK_IDLE;
	endproperty
	a_tx_clock_quiet: assert property (p_tx_clock_quiet) else $error("tx clock runs in reset");

	sequence s_even_captured;
		captured_even_q == $past(rx_symbols_even_pad);
	endsequence

	property p_even_capture;
		@(posedge buffered_receive_clock_even) disable iff (even_rst_q)
		!$past(even_rst_q) |-> s_even_captured;
	endproperty
	a_even_capture: assert property (p_even_capture) else $error("even pad not captured");

	property p_even_second_stage;
		@(posedge buffered_receive_clock_even) disable iff (even_rst_q)
		!$past(even_rst_q) |-> core_even_q == $past(captured_even_q);
	endproperty
	a_even_second_stage: assert property (p_even_second_stage) else $error("even not restaged");

	property p_odd_second_stage;
		@(posedge buffered_receive_clock_odd) disable iff (odd_rst_q)
		!$past(odd_rst_q) |-> core_odd_q == $past(captured_odd_q);
	endproperty
	a_odd_second_stage: assert property (p_odd_second_stage) else $error("odd not restaged");

	property p_single_shares_clock;
		@(posedge clock) disable iff (rst)
		SINGLE_CLOCK_CAPTURE |-> buffered_receive_clock_odd == receive_clock_even;
	endproperty
	a_single_shares_clock: assert property (p_single_shares_clock) else $error("odd clock not even");

	property p_pair_delivered;
		@(posedge clock) disable iff (rst)
		even_valid |-> ##[0:4] odd_valid || SINGLE_CLOCK_CAPTURE == 1'b0;
	endproperty
	a_pair_delivered: assert property (p_pair_delivered) else $error("odd word missing");

endmodule : tbi_io

/* File: verilog/tbi_io_pkg.sv */
package tbi_io_pkg;

	// width of one ten-bit code group
	localparam int SYMBOL_WIDTH = 10;
	// forwarded clock level driven in the first and second half of a core cycle
	localparam logic TX_CLOCK_FIRST_HALF = 1'b0;
	localparam logic TX_CLOCK_SECOND_HALF = 1'b1;
	// levels held while the core is in reset
	localparam logic TX_CLOCK_IDLE = 1'b0;
	localparam logic [SYMBOL_WIDTH-1:0] SYMBOLS_RESET = 10'h000;
	// core clock and link clock periods in ns
	localparam int CORE_PERIOD_NS = 10;
	localparam int LINK_PERIOD_NS = 125;
	// whole core cycles between two link words, rounded down
	localparam int LINK_WORD_SPACING = LINK_PERIOD_NS / CORE_PERIOD_NS;
	// core cycles the link reset outlasts rst, so slow link clocks see several edges
	localparam int RESET_STRETCH_CYCLES = 50;

endpackage : tbi_io_pkg

/* File: verilog/symbol_crossing.sv */
`timescale 1ns/1ps
// carries one receive bus from its link clock into the core clock by toggle handshake
module symbol_crossing #(
	parameter int WIDTH = tbi_io_pkg::SYMBOL_WIDTH
) (
	input wire logic link_clock,
	input wire logic link_rst,
	input wire logic [WIDTH-1:0] link_symbols,
	input wire logic clock,
	input wire logic rst,
	output logic [WIDTH-1:0] symbols,
	output logic symbols_valid
);

	logic [WIDTH-1:0] hold_q;
	logic toggle_q;
	logic sync1_q;
	logic sync2_q;
	logic seen_q;
	logic [WIDTH-1:0] symbols_q;
	logic valid_q;
	wire new_word = sync2_q ^ seen_q;

	// link side: hold the word and flip the toggle each link cycle
	always_ff @(posedge link_clock)
	begin
		if (link_rst)
		begin
			hold_q <= tbi_io_pkg::SYMBOLS_RESET;
			toggle_q <= 1'b0;
		end
		else
		begin
			hold_q <= link_symbols;
			toggle_q <= ~toggle_q;
		end
	end

	// core side: two flops on the toggle, then edge detect on the second only
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			seen_q <= 1'b0;
			symbols_q <= tbi_io_pkg::SYMBOLS_RESET;
			valid_q <= 1'b0;
		end
		else
		begin
			valid_q <= new_word; // pulse lands with the word it marks
			sync1_q <= toggle_q;
			sync2_q <= sync1_q;
			seen_q <= sync2_q;
			if (new_word)
				symbols_q <= hold_q; // hold_q is stable for many core cycles here
		end
	end

	assign symbols = symbols_q;
	assign symbols_valid = valid_q;

	property p_valid_spaced;
		@(posedge clock) disable iff (rst)
		valid_q |=> !valid_q [*8];
	endproperty
	a_valid_spaced: assert property (p_valid_spaced) else $error("word pulses too close");

	property p_symbols_hold;
		@(posedge clock) disable iff (rst)
		!new_word |=> $stable(symbols_q);
	endproperty
	a_symbols_hold: assert property (p_symbols_hold) else $error("symbols changed without word");

endmodule : symbol_crossing

/* File: verification/serdes_model.sv */
`timescale 1ns/1ps
// serdes stand-in: free-running receive clocks and a counting receive bus
module serdes_model (
	output logic receive_clock_even,
	output logic receive_clock_odd,
	output logic [9:0] rx_bus,
	output logic [7:0] pair_count
);
	// odd clock is the exact inverse, which dual-clock capture relies on
	assign receive_clock_odd = ~receive_clock_even;
	// own clock pair for this one instance only, phase unrelated to the core
	initial
	begin
		receive_clock_even = 1'b0;
		#3.3;
		forever #62.5 receive_clock_even = ~receive_clock_even;
	end
	// bus moves a quarter period after each edge so both samples stay clean
	initial
	begin
		pair_count = 8'h00;
		rx_bus = 10'h100;
		forever
		begin
			@(posedge receive_clock_even);
			#31;
			pair_count = pair_count + 8'h01;
			rx_bus = 10'h300 - {2'b00, pair_count};
			@(negedge receive_clock_even);
			#31;
			rx_bus = 10'h100 + {2'b00, pair_count};
		end
	end
endmodule : serdes_model

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic clock;
	logic rst;
	logic [9:0] tx_symbols;
	logic [9:0] tx_symbols_pad;
	logic tx_clock_pad;
	logic receive_clock_even;
	logic receive_clock_odd;
	logic [9:0] rx_bus;
	logic [7:0] pair_count;
	logic [9:0] captured_symbols_even;
	logic [9:0] captured_symbols_odd;
	logic [9:0] rx_symbols_even;
	logic [9:0] rx_symbols_odd;
	logic rx_symbols_valid;
	int mismatches;
	int samples_checked;

	// both pad copies carry the one bus, as the board routes each bit twice
	tbi_io tbi_io_inst (
		.clock(clock),
		.rst(rst),
		.tx_symbols(tx_symbols),
		.tx_symbols_pad(tx_symbols_pad),
		.tx_clock_pad(tx_clock_pad),
		.receive_clock_even(receive_clock_even),
		.receive_clock_odd(receive_clock_odd),
		.rx_symbols_even_pad(rx_bus),
		.rx_symbols_odd_pad(rx_bus),
		.captured_symbols_even(captured_symbols_even),
		.captured_symbols_odd(captured_symbols_odd),
		.rx_symbols_even(rx_symbols_even),
		.rx_symbols_odd(rx_symbols_odd),
		.rx_symbols_valid(rx_symbols_valid)
	);
	serdes_model serdes_model_inst (
		.receive_clock_even(receive_clock_even),
		.receive_clock_odd(receive_clock_odd),
		.rx_bus(rx_bus),
		.pair_count(pair_count)
	);

	// core clock, 100 MHz
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic summarize;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	// pads idle while reset holds
	task automatic test_reset;
		@(negedge clock);
		check("tx pad", tx_symbols_pad, tbi_io_pkg::SYMBOLS_RESET);
		check("tx clock", {9'h000, tx_clock_pad}, {9'h000, tbi_io_pkg::TX_CLOCK_IDLE});
		check("valid", {9'h000, rx_symbols_valid}, 10'h000);
		$display("test reset done");
	endtask : test_reset

	// back-to-back words, each one flop late; forwarded clock inverted
	task automatic test_transmit;
		logic [9:0] prev;
		prev = 10'h000;
		for (int i = 0; i < 12; i++)
		begin
			@(negedge clock);
			if (i > 0)
				check("tx pad", tx_symbols_pad, prev);
			prev = {i[4:0], ~i[4:0]};
			tx_symbols = prev;
			@(posedge clock);
			#2;
			check("tx clock high", {9'h000, tx_clock_pad}, 10'h000);
			#5;
			check("tx clock low", {9'h000, tx_clock_pad}, 10'h001);
		end
		$display("test transmit done");
	endtask : test_transmit

	// link-side capture on both edges, then words and pairing in core domain
	task automatic test_receive;
		logic [7:0] pc0;
		int k;
		// let the stretched link reset end and the pipeline fill
		repeat (150) @(negedge clock);
		for (int p = 0; p < 4; p++)
		begin
			@(posedge receive_clock_even);
			#1;
			pc0 = pair_count;
			check("cap even", captured_symbols_even, 10'h100 + {2'b00, pair_count});
			check("cap odd", captured_symbols_odd, 10'h300 - {2'b00, pair_count});
			k = 0;
			@(negedge clock);
			while (rx_symbols_valid !== 1'b1 && k < 40)
			begin
				@(negedge clock);
				k++;
			end
			if (k == 40)
			begin
				mismatches++;
				summarize();
			end
			// the crossing hands over the word captured two link edges back
			check("rx even", rx_symbols_even, 10'h100 + {2'b00, pc0 - 8'h02});
			repeat (5) @(negedge clock);
			check("rx odd", rx_symbols_odd, 10'h300 - {2'b00, pc0 - 8'h02});
		end
		$display("test receive done");
	endtask : test_receive

	// six cycles of reset; the design stretches it for the link clocks
	initial
	begin
		mismatches = 0;
		samples_checked = 0;
		rst = 1'b1;
		tx_symbols = 10'h000;
		repeat (5) @(negedge clock);
		test_reset();
		rst = 1'b0;
		test_transmit();
		test_receive();
		summarize();
	end
endmodule : tb_top
